//--- pkg/daq_io_if.sv
// Link between the host controller and the acquisition board I/O logic
`timescale 1ns/1ps
`default_nettype none
interface daq_io_if;
	import daq_io_pkg::*;
	logic wr_stb;
	logic rd_stb;
	link_addr_t addr;
	link_data_t wdata;
	link_data_t rdata;
	logic irq_line;
	logic error_line_n;
	host_link_mode_e host_link_mode;
	modport host (output wr_stb, output rd_stb, output addr, output wdata,
		output host_link_mode, input rdata, input irq_line, input error_line_n);
	modport device (input wr_stb, input rd_stb, input addr, input wdata,
		input host_link_mode, output rdata, output irq_line, output error_line_n);
endinterface
`default_nettype wire

//--- pkg/daq_io_pkg.sv
// Types shared by both ends of the user I/O link
package daq_io_pkg;
	typedef enum logic [1:0] {
		link_byte_bidir,
		link_epp,
		link_ecp_bidir,
		link_ecp_epp
	} host_link_mode_e;
	typedef enum logic {
		fmt_twos_complement,
		fmt_offset_binary
	} sample_format_select_e;
	typedef logic [3:0] link_addr_t;
	typedef logic [7:0] link_data_t;
endpackage

//--- pkg/daq_io_regs.svh
// Offsets, field positions and reset values of the user I/O link
`ifndef DAQ_IO_REGS_SVH
`define DAQ_IO_REGS_SVH
`define DEV_ADDR_USER_IN 4'h0
`define DEV_ADDR_USER_OUT 4'h1
`define DEV_ADDR_LAMP 4'h2
`define DEV_ADDR_IRQ_ON 4'h3
`define DEV_ADDR_IRQ_OFF 4'h4
`define DEV_ADDR_CFG 4'h5
`define DEV_ADDR_STATUS 4'h6
`define CFG_FMT_BIT 0
`define CFG_GAIN_LSB 1
`define CFG_SPEED_LSB 4
`define CFG_RESET 8'h00
`define USER_OUT_RESET 4'h0
`define HOST_REG_CMD 4'h0
`define HOST_REG_DATA 4'h1
`define HOST_REG_RESULT 4'h2
`define HOST_REG_STATUS 4'h3
`define HOST_REG_IRQ_STATUS 4'h4
`define HOST_REG_IRQ_CLEAR 4'h5
`define HOST_REG_IRQ_ENABLE 4'h6
`define HOST_REG_MODE 4'h7
`define HOST_MODE_RESET 2'h1
`define GAIN_UNITY 3'h0
`define SPEED_MAX 3'h4
`endif

//--- src/daq_io_device.sv
// Board-side user I/O, lamp, interrupt routing, supply status and converter config
`timescale 1ns/1ps
`default_nettype none
`include "daq_io_regs.svh"
module daq_io_device #(
	parameter int NUM_CONV = 4
) (
	input wire logic sys_clk,
	input wire logic reset,
	daq_io_if.device link,
	input wire logic [3:0] user_in_pin,
	input wire logic supply_ok_pin,
	output logic [3:0] user_out,
	output logic lamp_output,
	output logic [7:0] conv_cfg [NUM_CONV],
	output logic [1:0] link_mode_seen
);
	import daq_io_pkg::*;
	logic [4:0] sync_v;
	logic [3:0] user_in_s;
	logic supply_ok_status;
	logic irq_route_on_q;
	logic [7:0] cfg_q;
	logic [7:0] rdata_q;
	logic err_n_q;
	logic irq_q;

	pin_sync #(.WIDTH(5)) u_sync (
		.sys_clk(sys_clk),
		.reset(reset),
		.async_in({supply_ok_pin, user_in_pin}),
		.sync_out(sync_v)
	);
	assign user_in_s = sync_v[3:0];
	assign supply_ok_status = sync_v[4];

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			user_out <= `USER_OUT_RESET;
		end else if (link.wr_stb && link.addr == `DEV_ADDR_USER_OUT) begin
			user_out <= link.wdata[3:0];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			lamp_output <= 1'b0;
		end else if (link.wr_stb && link.addr == `DEV_ADDR_LAMP) begin
			lamp_output <= link.wdata[0];
		end
	end

	// Enable and disable are distinct addresses so neither needs a read-modify-write
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			irq_route_on_q <= 1'b0;
		end else if (link.wr_stb && link.addr == `DEV_ADDR_IRQ_ON) begin
			irq_route_on_q <= 1'b1;
		end else if (link.wr_stb && link.addr == `DEV_ADDR_IRQ_OFF) begin
			irq_route_on_q <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			irq_q <= 1'b0;
			err_n_q <= 1'b1;
		end else begin
			irq_q <= irq_route_on_q & ~user_in_s[3];
			err_n_q <= ~supply_ok_status;
		end
	end
	assign link.irq_line = irq_q;
	assign link.error_line_n = err_n_q;

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			cfg_q <= `CFG_RESET;
		end else if (link.wr_stb && link.addr == `DEV_ADDR_CFG) begin
			cfg_q <= link.wdata;
		end
	end

	// A single register fans out, so no converter can differ from the rest
	genvar gi;
	generate
		for (gi = 0; gi < NUM_CONV; gi++) begin : g_conv
			assign conv_cfg[gi] = cfg_q;
		end
	endgenerate

	assign link_mode_seen = link.host_link_mode;

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			rdata_q <= 8'h00;
		end else if (link.rd_stb) begin
			if (link.addr == `DEV_ADDR_USER_IN) begin
				rdata_q <= {4'h0, user_in_s};
			end else if (link.addr == `DEV_ADDR_USER_OUT) begin
				rdata_q <= {4'h0, user_out};
			end else if (link.addr == `DEV_ADDR_LAMP) begin
				rdata_q <= {7'h00, lamp_output};
			end else if (link.addr == `DEV_ADDR_CFG) begin
				rdata_q <= cfg_q;
			end else if (link.addr == `DEV_ADDR_STATUS) begin
				rdata_q <= {6'h00, irq_route_on_q, supply_ok_status};
			end else begin
				rdata_q <= 8'h00;
			end
		end
	end
	assign link.rdata = rdata_q;
endmodule
`default_nettype wire

//--- src/daq_io_host.sv
// Host-side controller: register port to link transactions, interrupts
//
// Design decisions made here: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "daq_io_regs.svh"
module daq_io_host (
	input wire logic sys_clk,
	input wire logic reset,
	daq_io_if.host link,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	output logic irq
);
	import daq_io_pkg::*;
	// Commands: bit7 = read, low nibble = device address
	logic [7:0] cmd_q;
	logic [7:0] data_q;
	logic [7:0] result_q;
	logic go_q;
	logic capture_q;
	logic [1:0] mode_q;
	logic [2:0] ists_q;
	logic [2:0] ien_q;
	logic [2:0] ev;
	logic [1:0] pin_s;
	logic irq_s_q;
	logic good_s_q;
	logic [7:0] rdata_q;

	pin_sync #(.WIDTH(2)) u_sync (
		.sys_clk(sys_clk),
		.reset(reset),
		// Error line enters as a good flag: cleared flops then match its reset level
		.async_in({~link.error_line_n, link.irq_line}),
		.sync_out(pin_s)
	);

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			cmd_q <= 8'h00;
			data_q <= 8'h00;
			mode_q <= `HOST_MODE_RESET;
			go_q <= 1'b0;
		end else begin
			go_q <= reg_wr && reg_addr == `HOST_REG_CMD;
			if (reg_wr && reg_addr == `HOST_REG_CMD) begin
				cmd_q <= reg_wdata;
			end
			if (reg_wr && reg_addr == `HOST_REG_DATA) begin
				data_q <= reg_wdata;
			end
			if (reg_wr && reg_addr == `HOST_REG_MODE) begin
				mode_q <= reg_wdata[1:0];
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			link.wr_stb <= 1'b0;
			link.rd_stb <= 1'b0;
			link.addr <= 4'h0;
			link.wdata <= 8'h00;
		end else begin
			link.wr_stb <= go_q & ~cmd_q[7];
			link.rd_stb <= go_q & cmd_q[7];
			link.addr <= cmd_q[3:0];
			link.wdata <= data_q;
		end
	end
	assign link.host_link_mode = host_link_mode_e'(mode_q);

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			capture_q <= 1'b0;
			result_q <= 8'h00;
		end else begin
			capture_q <= link.rd_stb;
			if (capture_q) begin
				result_q <= link.rdata;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			irq_s_q <= 1'b0;
			good_s_q <= 1'b0;
		end else begin
			irq_s_q <= pin_s[0];
			good_s_q <= pin_s[1];
		end
	end

	// Events: read done, interrupt rise, supply went bad; set beats clear
	assign ev = {~pin_s[1] & good_s_q, pin_s[0] & ~irq_s_q, capture_q};
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			ists_q <= 3'h0;
			ien_q <= 3'h0;
		end else begin
			if (reg_wr && reg_addr == `HOST_REG_IRQ_ENABLE) begin
				ien_q <= reg_wdata[2:0];
			end
			if (reg_wr && reg_addr == `HOST_REG_IRQ_CLEAR) begin
				ists_q <= (ists_q & ~reg_wdata[2:0]) | ev;
			end else begin
				ists_q <= ists_q | ev;
			end
		end
	end
	assign irq = |(ists_q & ien_q);

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			rdata_q <= 8'h00;
		end else if (reg_rd) begin
			if (reg_addr == `HOST_REG_CMD) begin
				rdata_q <= cmd_q;
			end else if (reg_addr == `HOST_REG_DATA) begin
				rdata_q <= data_q;
			end else if (reg_addr == `HOST_REG_RESULT) begin
				rdata_q <= result_q;
			end else if (reg_addr == `HOST_REG_STATUS) begin
				rdata_q <= {6'h00, pin_s[0], ~pin_s[1]};
			end else if (reg_addr == `HOST_REG_IRQ_STATUS) begin
				rdata_q <= {5'h00, ists_q};
			end else if (reg_addr == `HOST_REG_IRQ_ENABLE) begin
				rdata_q <= {5'h00, ien_q};
			end else if (reg_addr == `HOST_REG_MODE) begin
				rdata_q <= {6'h00, mode_q};
			end else begin
				rdata_q <= 8'h00;
			end
		end
	end
	assign reg_rdata = rdata_q;
endmodule
`default_nettype wire

//--- src/pin_sync.sv
// Two-flop synchroniser for a bus of asynchronous pins
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
	parameter int WIDTH = 5
) (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_q;
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			meta_q <= '0;
			sync_out <= '0;
		end else begin
			meta_q <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule
`default_nettype wire

//--- tb/daq_io_asserts.sv
// Link checker: readback, interrupt routing and reset behaviour of the board end
`timescale 1ns/1ps
`default_nettype none
`include "daq_io_regs.svh"
module daq_io_asserts (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic wr_stb,
	input wire logic rd_stb,
	input wire daq_io_pkg::link_addr_t addr,
	input wire daq_io_pkg::link_data_t wdata,
	input wire daq_io_pkg::link_data_t rdata,
	input wire logic irq_line,
	input wire logic error_line_n
);
	import daq_io_pkg::*;
	logic route_q;
	logic lamp_q;
	logic [3:0] out_q;
	link_data_t cfg_q;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	// Shadow of what the host has written, so readbacks can be judged
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			route_q <= 1'b0;
			lamp_q <= 1'b0;
			out_q <= `USER_OUT_RESET;
			cfg_q <= `CFG_RESET;
		end else if (wr_stb) begin
			if (addr == `DEV_ADDR_IRQ_ON) route_q <= 1'b1;
			if (addr == `DEV_ADDR_IRQ_OFF) route_q <= 1'b0;
			if (addr == `DEV_ADDR_LAMP) lamp_q <= wdata[0];
			if (addr == `DEV_ADDR_USER_OUT) out_q <= wdata[3:0];
			if (addr == `DEV_ADDR_CFG) cfg_q <= wdata;
		end
	end
	sequence s_rd(link_addr_t a);
		rd_stb && addr == a;
	endsequence
	a_strobe_excl: assert property (!(wr_stb && rd_stb)) else $error("both strobes high");
	a_reset_idle: assert property ($fell(reset) |-> !irq_line && error_line_n)
		else $error("link not idle after reset");
	a_unmapped_zero: assert property (rd_stb && addr > `DEV_ADDR_STATUS |=> rdata == 8'h00)
		else $error("unmapped read not zero");
	a_route_off_low: assert property (wr_stb && addr == `DEV_ADDR_IRQ_OFF |-> ##2 !irq_line)
		else $error("interrupt line still high after routing off");
	a_irq_needs_route: assert property (irq_line |-> $past(route_q))
		else $error("interrupt line high with routing off");
	a_cfg_readback: assert property (s_rd(`DEV_ADDR_CFG) |=> rdata[6:0] == cfg_q[6:0])
		else $error("config readback differs");
	a_lamp_readback: assert property (s_rd(`DEV_ADDR_LAMP) |=> rdata[0] == lamp_q)
		else $error("lamp readback differs");
	a_out_readback: assert property (s_rd(`DEV_ADDR_USER_OUT) |=> rdata[3:0] == out_q)
		else $error("user output readback differs");
endmodule
`default_nettype wire

//--- tb/tb.sv
// Bench: host controller and board end joined over the link
`timescale 1ns/1ps
`default_nettype none
`include "daq_io_regs.svh"
module tb;
	import daq_io_pkg::*;
	typedef struct {logic [3:0] a; logic [7:0] d; logic [7:0] m;} row_s;
	logic sys_clk = 1'b0;
	logic reset = 1'b1;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	logic irq;
	logic [3:0] user_in_pin = 4'h5;
	logic supply_ok_pin = 1'b1;
	logic [3:0] user_out;
	logic lamp_output;
	logic [7:0] conv_cfg [4];
	logic [1:0] link_mode_seen;
	logic [7:0] v;
	int n_errors = 0;
	int compares = 0;
	// Top gain only with the slowest modulator setting, to stay inside the gain-speed limit
	row_s rows [8] = '{'{`DEV_ADDR_USER_OUT, 8'h0A, 8'h0F}, '{`DEV_ADDR_USER_OUT, 8'h05, 8'h0F},
		'{`DEV_ADDR_LAMP, 8'h00, 8'h01}, '{`DEV_ADDR_LAMP, 8'h01, 8'h01},
		'{`DEV_ADDR_CFG, 8'h40, 8'hFF},
		'{`DEV_ADDR_CFG, 8'h0E, 8'hFF},
		'{`DEV_ADDR_CFG, 8'h31, 8'hFF}, '{`DEV_ADDR_CFG, 8'h41, 8'hFF}};
	daq_io_if link_bus();
	daq_io_host daq_io_host_i(.sys_clk(sys_clk), .reset(reset), .link(link_bus),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .irq(irq));
	daq_io_device daq_io_device_i(.sys_clk(sys_clk), .reset(reset), .link(link_bus),
		.user_in_pin(user_in_pin), .supply_ok_pin(supply_ok_pin), .user_out(user_out),
		.lamp_output(lamp_output), .conv_cfg(conv_cfg), .link_mode_seen(link_mode_seen));
	daq_io_asserts daq_io_asserts_i(.sys_clk(sys_clk), .reset(reset), .wr_stb(link_bus.wr_stb),
		.rd_stb(link_bus.rd_stb), .addr(link_bus.addr), .wdata(link_bus.wdata),
		.rdata(link_bus.rdata), .irq_line(link_bus.irq_line), .error_line_n(link_bus.error_line_n));
	always #50 sys_clk = ~sys_clk;
	task wt(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	task rd(input logic [3:0] a, output logic [7:0] o);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 o = reg_rdata;
	endtask
	// Fixed wait is enough: the controller answers a command within four cycles
	task dw(input logic [3:0] a, input logic [7:0] d);
		wr(`HOST_REG_DATA, d);
		wr(`HOST_REG_CMD, {4'h0, a});
		wt(6);
	endtask
	task dr(input logic [3:0] a, output logic [7:0] o);
		wr(`HOST_REG_CMD, {4'h8, a});
		wt(6);
		rd(`HOST_REG_RESULT, o);
	endtask
	task chk(input string name, input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask
	task end_of_test;
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge sys_clk);
		n_errors++;
		end_of_test();
	end
	initial begin
		repeat (16) @(posedge sys_clk);
		reset <= 1'b0;
		foreach (rows[i]) begin
			dw(rows[i].a, rows[i].d);
			dr(rows[i].a, v);
			chk("rdbk", v & rows[i].m, rows[i].d & rows[i].m);
		end
		chk("out", {4'h0, user_out}, 8'h05);
		chk("lamp", {7'h0, lamp_output}, 8'h01);
		foreach (conv_cfg[k]) chk("cfg", conv_cfg[k], 8'h41);
		chk("fmt", {7'h0, conv_cfg[0][`CFG_FMT_BIT]}, 8'(fmt_offset_binary));
		for (int m = 0; m < 4; m++) begin
			wr(`HOST_REG_MODE, 8'(m));
			wt(2);
			chk("mode", {6'h0, link_mode_seen}, 8'(m));
		end
		wr(`HOST_REG_IRQ_CLEAR, 8'hFF);
		wr(`HOST_REG_IRQ_ENABLE, 8'h02);
		dw(`DEV_ADDR_IRQ_ON, 8'h00);
		wt(4);
		chk("irq", {7'h0, irq}, 8'h01);
		wr(`HOST_REG_IRQ_ENABLE, 8'h00);
		wt(1);
		chk("mask", {7'h0, irq}, 8'h00);
		wr(`HOST_REG_IRQ_CLEAR, 8'h02);
		wr(`HOST_REG_IRQ_ENABLE, 8'h02);
		wt(1);
		chk("clr", {7'h0, irq}, 8'h00);
		@(posedge sys_clk) user_in_pin <= 4'hD;
		wt(10);
		chk("in3hi", {7'h0, link_bus.irq_line}, 8'h00);
		@(posedge sys_clk) user_in_pin <= 4'h5;
		wt(10);
		chk("in3lo", {7'h0, link_bus.irq_line}, 8'h01);
		dw(`DEV_ADDR_IRQ_OFF, 8'h00);
		chk("off", {7'h0, link_bus.irq_line}, 8'h00);
		dr(`DEV_ADDR_USER_IN, v);
		chk("in", v & 8'h0F, 8'h05);
		@(posedge sys_clk) supply_ok_pin <= 1'b0;
		wt(10);
		rd(`HOST_REG_STATUS, v);
		chk("bad", v & 8'h01, 8'h01);
		rd(`HOST_REG_IRQ_STATUS, v);
		chk("erise", v & 8'h04, 8'h04);
		@(posedge sys_clk) supply_ok_pin <= 1'b1;
		wt(10);
		chk("good", {7'h0, link_bus.error_line_n}, 8'h00);
		dr(4'hF, v);
		chk("unm", v, 8'h00);
		dw(`DEV_ADDR_IRQ_ON, 8'h00);
		@(posedge sys_clk) reset <= 1'b1;
		wt(4);
		@(posedge sys_clk) reset <= 1'b0;
		wt(1);
		chk("rst", {user_out, 3'h0, lamp_output}, 8'h00);
		chk("rmode", {6'h0, link_mode_seen}, 8'(link_epp));
		// Long enough for the pins to resettle, so a routing left on would show
		wt(8);
		chk("rirq", {7'h0, link_bus.irq_line}, 8'h00);
		rd(`HOST_REG_IRQ_STATUS, v);
		chk("rists", v, 8'h00);
		end_of_test();
	end
endmodule
`default_nettype wire
